// file: sim/som_burst_addr_tb.sv
`timescale 1ns/1ps
module som_burst_addr_tb;
  import som_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic out_ready = 1'h0;
  logic cke, cs_n, ras_n, cas_n, mode_load_strobe_n, word_wide;
  logic [ADDR_W-1:0] addr;
  logic [2:0] read_latency;
  logic [1:0] burst_count;
  logic burst_interleave, mode_error, out_valid, out_wide, out_last, busy;
  logic [PROG_W-1:0] out_prog_addr;
  logic [ADDR_W-1:0] out_row;
  logic [COL_W-1:0] out_col;
  logic [2:0] lats [4] = '{LAT_CODE_4, LAT_CODE_6, LAT_CODE_5, LAT_CODE_4};
  int fail_count = 0;
  int n_compared = 0;
  always #20 mclk = ~mclk;
  som_ctrl_model ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .mode_load_strobe_n(mode_load_strobe_n), .word_wide(word_wide), .addr(addr));
  som_burst_addr dut (.mclk(mclk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .mode_load_strobe_n(mode_load_strobe_n), .word_wide(word_wide), .addr(addr),
    .read_latency(read_latency), .burst_interleave(burst_interleave), .burst_count(burst_count),
    .mode_error(mode_error), .out_valid(out_valid), .out_ready(out_ready), .out_prog_addr(out_prog_addr),
    .out_row(out_row), .out_col(out_col), .out_wide(out_wide), .out_last(out_last), .busy(busy));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_mode(input logic [2:0] lat, input logic ord, input logic [1:0] len, input logic err);
    repeat (2) @(negedge mclk);
    chk("read_latency", lat, read_latency);
    chk("burst_interleave", ord, burst_interleave);
    chk("burst_count", len, burst_count);
    chk("mode_error", err, mode_error);
  endtask
  // ready toggles when stalling so the two-entry buffer fills
  task automatic burst(input logic [12:0] row_a, input logic [8:0] col_a, input logic w, input logic ilv,
    input logic [2:0] lat, input int beats, input logic stall);
    logic [2:0] idx;
    logic [8:0] col;
    int n;
    int got;
    int first;
    ctl.row(row_a);
    ctl.read(w, col_a);
    got = 0;
    first = -1;
    for (n = 0; n < 80 && got < beats; n++) begin
      @(posedge mclk);
      out_ready <= stall ? n[1] : 1'h1;
      @(negedge mclk);
      if (out_valid === 1'h1 && first < 0) begin
        first = n;
        chk("first_beat", 32'(lat) + 32'h2, first);
        chk("busy", 1'h1, busy);
      end
      if (out_valid === 1'h1 && out_ready === 1'h1) begin
        idx = ilv ? (col_a[2:0] ^ got[2:0]) : (col_a[2:0] + got[2:0]);
        idx = (beats == 4) ? {col_a[2], idx[1:0]} : idx;
        col = {col_a[8:3], idx};
        chk("out_prog_addr", w ? {row_a, col[7:0], 1'h0} : {row_a, col}, out_prog_addr);
        chk("out_row", row_a, out_row);
        chk("out_col", w ? {1'h0, col[7:0]} : col, out_col);
        chk("out_last", got == beats - 1, out_last);
        chk("out_wide", w, out_wide);
        got++;
      end
    end
    for (n = 0; n < 20 && busy !== 1'h0; n++) @(negedge mclk);
    if (got != beats || busy !== 1'h0) begin
      fail_count++;
      $display("CHECK FAILED beats expected %0d seen %0d", beats, got);
      print_verdict();
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    check_mode(LAT_CODE_5, 1'h0, LEN_CODE_4, 1'h0);
    burst(13'h1abc, 9'h0a6, 1'h0, 1'h0, LAT_CODE_5, 4, 1'h0);
    for (int k = 0; k < 4; k++) begin
      ctl.load_mode(lats[k], k[0], k[1] ? LEN_CODE_8 : LEN_CODE_4);
      check_mode(lats[k], k[0], k[1] ? LEN_CODE_8 : LEN_CODE_4, 1'h0);
      burst(13'h0f0f + 13'(k), 9'h1f0 + 9'(k * 3), k[0] ^ k[1], k[0], lats[k], k[1] ? 8 : 4, k[0]);
    end
    // reserved codes are kept but flagged
    ctl.load_mode(3'h7, 1'h0, 2'h3);
    check_mode(3'h7, 1'h0, 2'h3, 1'h1);
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    check_mode(LAT_CODE_5, 1'h0, LEN_CODE_4, 1'h0);
    print_verdict();
  end
endmodule

// file: sim/som_ctrl_model.sv
`timescale 1ns/1ps
module som_ctrl_model (
  // clock
  input wire logic mclk,
  // command pins toward the device
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic mode_load_strobe_n,
  output logic word_wide,
  output logic [som_pkg::ADDR_W-1:0] addr
);
  import som_pkg::*;
  initial begin
    {cke, cs_n, ras_n, cas_n, mode_load_strobe_n, word_wide, addr} = {5'h1f, 1'h0, 13'h0};
  end
  // valid pins while selected
  // deselected pins carry inverted values so stale levels are never trusted
  task automatic issue(input logic r, input logic c, input logic m, input logic w, input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    {cs_n, ras_n, cas_n, mode_load_strobe_n, word_wide, addr} <= {1'h0, r, c, m, w, a};
    @(posedge mclk);
    {cs_n, ras_n, cas_n, mode_load_strobe_n, word_wide, addr} <= {1'h1, ~r, ~c, ~m, ~w, ~a};
  endtask
  // reserved codes only where a test wants the flag
  task automatic load_mode(input logic [2:0] lat, input logic ord, input logic [1:0] len);
    issue(1'h0, 1'h0, 1'h0, 1'h0, {7'h0, lat, ord, len});
    repeat (3) @(posedge mclk);
  endtask
  task automatic row(input logic [ADDR_W-1:0] row_a);
    issue(1'h0, 1'h1, 1'h1, 1'h0, row_a);
  endtask
  task automatic read(input logic w, input logic [COL_W-1:0] col_a);
    issue(1'h1, 1'h0, 1'h1, w, {4'ha, col_a});
  endtask
endmodule

// file: verilog/som_burst_addr.sv
// Functional notes
// - mode load: A5..A3 latency 4/5/6, A2 order, A1..A0 length 4/8
// - mode register takes its default at power-up without any command
// - default mode: latency five, sequential order, length four
// - four-beat burst wraps in aligned group of four, seq or xor
// - eight-beat burst wraps in aligned group of eight, seq or xor
// - x32: row on A0..A12, column on A0..A7, A8..A12 ignored
// - x16: row on A0..A12, column on A0..A8, A9..A12 ignored
// - wrap at column bit one or two; higher column bits fixed
// - x32 location holds even word low half, odd word high half
// - x16: programmer bits 0..8 column, 9..21 row
// - all inputs except rst_n sampled and actions timed on rising clock edge; rst_n resets asynchronously
// - width select sampled with each read, high is 32-bit
`timescale 1ns/1ps
module som_burst_addr #(
  parameter int LAT_MAX = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic mode_load_strobe_n,
  input wire logic word_wide,
  input wire logic [som_pkg::ADDR_W-1:0] addr,
  // mode view
  output logic [2:0] read_latency,
  output logic burst_interleave,
  output logic [1:0] burst_count,
  output logic mode_error,
  // burst address stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [som_pkg::PROG_W-1:0] out_prog_addr,
  output logic [som_pkg::ADDR_W-1:0] out_row,
  output logic [som_pkg::COL_W-1:0] out_col,
  output logic out_wide,
  output logic out_last,
  output logic busy
);
  import som_pkg::*;

  // pin synchronisers; the first stage is read by the second only
  logic [ADDR_W+5:0] pin_s1_q;
  logic [ADDR_W+5:0] pin_s2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {cke, cs_n, ras_n, cas_n, mode_load_strobe_n, word_wide, addr};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic s_cke;
  logic s_cs_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_mls_n;
  logic s_wide;
  logic [ADDR_W-1:0] s_addr;
  assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_mls_n, s_wide, s_addr} = pin_s2_q;

  function automatic som_cmd_t decode(input logic ce, input logic cs, input logic row_s, input logic col_s,
                                      input logic ml);
    som_cmd_t c;
    c = SOM_CMD_NOP;
    if (ce && !cs) begin
      if (!row_s && !col_s && !ml) c = SOM_CMD_MODE;
      else if (!row_s && col_s && ml) c = SOM_CMD_ROW;
      else if (row_s && !col_s && ml) c = SOM_CMD_READ;
    end
    return c;
  endfunction

  // beat offset within the wrap group
  function automatic logic [2:0] beat_offset(input logic [2:0] start, input logic [2:0] beat,
                                             input logic ilv, input logic len8);
    logic [2:0] r;
    r = ilv ? (start ^ beat) : 3'(start + beat);
    if (!len8) r[2] = start[2];
    return r;
  endfunction

  som_cmd_t cmd;
  som_state_t state_q;
  logic stall;
  assign cmd = decode(s_cke, s_cs_n, s_ras_n, s_cas_n, s_mls_n);

  // mode register
  logic [2:0] lat_q;
  logic ord_q;
  logic [1:0] len_q;
  logic err_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= RST_LATENCY;
      ord_q <= RST_ORDER;
      len_q <= RST_LENGTH;
    end else if (cmd == SOM_CMD_MODE && state_q == SOM_IDLE) begin
      lat_q <= s_addr[MODE_LAT_HI:MODE_LAT_LO];
      ord_q <= s_addr[MODE_ORDER_BIT];
      len_q <= s_addr[MODE_LEN_HI:MODE_LEN_LO];
    end
  end

  // flag reserved codes or A7/A8 high; sticky until reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (cmd == SOM_CMD_MODE && state_q == SOM_IDLE) begin
      err_q <= err_q | s_addr[MODE_RSV_A7] | s_addr[MODE_RSV_A8]
             | !(s_addr[MODE_LAT_HI:MODE_LAT_LO] inside {LAT_CODE_4, LAT_CODE_5, LAT_CODE_6})
             | !(s_addr[MODE_LEN_HI:MODE_LEN_LO] inside {LEN_CODE_4, LEN_CODE_8});
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_latency <= RST_LATENCY;
      burst_interleave <= RST_ORDER;
      burst_count <= RST_LENGTH;
      mode_error <= 1'b0;
    end else begin
      read_latency <= lat_q;
      burst_interleave <= ord_q;
      burst_count <= len_q;
      mode_error <= err_q;
    end
  end

  // row latch, kept until the next row command
  logic [ADDR_W-1:0] row_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) row_q <= '0;
    else if (cmd == SOM_CMD_ROW) row_q <= s_addr;
  end

  // read capture
  logic [COL_W-1:0] col_q;
  logic wide_q;
  logic ilv_q;
  logic len8_q;
  logic [2:0] beat_q;
  logic [2:0] wait_q;
  logic take_read;
  assign take_read = cmd == SOM_CMD_READ && state_q == SOM_IDLE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      col_q <= '0;
      wide_q <= 1'b0;
      ilv_q <= RST_ORDER;
      len8_q <= 1'b0;
    end else if (take_read) begin
      col_q <= s_wide ? {1'b0, s_addr[COL_W-2:0]} : s_addr[COL_W-1:0];
      wide_q <= s_wide;
      ilv_q <= ord_q;
      len8_q <= len_q == LEN_CODE_8;
    end
  end

  // sequencer: wait out the latency, then one beat per cycle unless stalled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SOM_IDLE;
      wait_q <= '0;
    end else begin
      unique case (state_q)
        SOM_IDLE: begin
          if (take_read) begin
            state_q <= SOM_WAIT;
            wait_q <= 3'(lat_q - LAT_CODE_4 + 3'h2);
          end
        end
        SOM_WAIT: begin
          if (wait_q == 3'h0) state_q <= SOM_BURST;
          else wait_q <= wait_q - 3'h1;
        end
        SOM_BURST: begin
          if (!stall && beat_q == (len8_q ? 3'h7 : 3'h3)) state_q <= SOM_IDLE;
        end
        default: state_q <= SOM_IDLE;
      endcase
    end
  end

  // one step per unstalled cycle from zero, cleared outside the burst
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) beat_q <= '0;
    else if (state_q != SOM_BURST) beat_q <= '0;
    else if (!stall) beat_q <= beat_q + 3'h1;
  end

  logic [COL_W-1:0] cur_col;
  logic [2:0] off;
  logic [PROG_W-1:0] cur_prog;
  logic cur_last;
  always_comb begin
    off = beat_offset(col_q[2:0], beat_q, ilv_q, len8_q);
    cur_col = {col_q[COL_W-1:3], off};
    cur_last = beat_q == (len8_q ? 3'h7 : 3'h3);
    // programmer word address; x32 points at the even word
    if (wide_q) cur_prog = {row_q, cur_col[COL_W-2:0], 1'b0};
    else cur_prog = {row_q, cur_col};
  end

  // two-entry skid buffer toward the reader
  logic [PROG_W+ADDR_W+COL_W+1:0] buf_q [2];
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign stall = cnt_q == 2'h2;
  assign push = state_q == SOM_BURST && !stall;
  assign pop = out_valid && out_ready;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (pop) buf_q[0] <= buf_q[1];
      if (push) buf_q[(pop ? cnt_q - 2'h1 : cnt_q) == 2'h0 ? 0 : 1] <=
          {cur_prog, row_q, cur_col, wide_q, cur_last};
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      out_valid <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
      busy <= state_q != SOM_IDLE || take_read;
    end
  end
  assign {out_prog_addr, out_row, out_col, out_wide, out_last} = buf_q[0];

  logic [2:0] pr_beat_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pr_beat_q <= '0;
    else pr_beat_q <= beat_q;
  end

  mode_default_a: assert property (@(posedge mclk) $rose(rst_n) |->
    lat_q == LAT_CODE_5 && !ord_q && len_q == LEN_CODE_4)
    else $error("mode default wrong");
  mode_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd == SOM_CMD_MODE && state_q == SOM_IDLE |=> lat_q == $past(s_addr[MODE_LAT_HI:MODE_LAT_LO])
    && ord_q == $past(s_addr[MODE_ORDER_BIT]) && len_q == $past(s_addr[MODE_LEN_HI:MODE_LEN_LO]))
    else $error("mode load not stored");
  // high column bits fixed between beats
  col_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && !cur_last |=> cur_col[COL_W-1:3] == $past(cur_col[COL_W-1:3]))
    else $error("high column moved");
  // four-beat burst keeps bit two and up
  wrap_four_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && !len8_q && !cur_last |=> cur_col[COL_W-1:2] == $past(cur_col[COL_W-1:2]))
    else $error("four beat wrap broken");
  // sequential eight-beat step wraps mod eight
  seq_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && !ilv_q && len8_q && !cur_last |=> cur_col[2:0] == 3'($past(cur_col[2:0]) + 3'h1))
    else $error("sequential order broken");
  // interleaved offsets follow start xor beat
  ilv_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && ilv_q && !cur_last |=> (cur_col[2:0] ^ $past(cur_col[2:0])) == (beat_q ^ pr_beat_q))
    else $error("interleave order broken");
  beat_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == SOM_BURST && !stall && !cur_last |=> beat_q == 3'(pr_beat_q + 3'h1))
    else $error("beat did not step");
  width_take_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take_read |=> wide_q == $past(s_wide))
    else $error("width not sampled");
  // x32 words leave on the even address
  even_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    out_valid && out_wide |-> !out_prog_addr[0])
    else $error("x32 not even word");
  col_x32_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take_read && s_wide |=> !col_q[COL_W-1])
    else $error("x32 column too wide");

  cov_burst8_c: cover property (@(posedge mclk) disable iff (!rst_n) state_q == SOM_BURST && len8_q && cur_last);
  cov_ilv_c: cover property (@(posedge mclk) disable iff (!rst_n) state_q == SOM_BURST && ilv_q);
  cov_stall_c: cover property (@(posedge mclk) disable iff (!rst_n) stall);
  cov_x32_c: cover property (@(posedge mclk) disable iff (!rst_n) take_read && s_wide);
endmodule

// file: verilog/som_pkg.sv
package som_pkg;
  // mode field positions on the address pins
  localparam int MODE_LAT_HI = 5;
  localparam int MODE_LAT_LO = 3;
  localparam int MODE_ORDER_BIT = 2;
  localparam int MODE_LEN_HI = 1;
  localparam int MODE_LEN_LO = 0;
  localparam int MODE_RSV_A7 = 7;
  localparam int MODE_RSV_A8 = 8;
  // latency codes
  localparam logic [2:0] LAT_CODE_4 = 3'h3;
  localparam logic [2:0] LAT_CODE_5 = 3'h4;
  localparam logic [2:0] LAT_CODE_6 = 3'h5;
  // burst length codes
  localparam logic [1:0] LEN_CODE_4 = 2'h1;
  localparam logic [1:0] LEN_CODE_8 = 2'h2;
  // power-up mode: latency 5, sequential, length 4
  localparam logic [2:0] RST_LATENCY = LAT_CODE_5;
  localparam logic RST_ORDER = 1'h0;
  localparam logic [1:0] RST_LENGTH = LEN_CODE_4;
  // address widths
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int PROG_W = 22;
  // commands, decoded from cke, cs_n, ras_n, cas_n, mode_load_strobe_n
  typedef enum logic [1:0] {
    SOM_CMD_NOP = 2'h0,
    SOM_CMD_MODE = 2'h1,
    SOM_CMD_ROW = 2'h3,
    SOM_CMD_READ = 2'h2
  } som_cmd_t;
  typedef enum logic [1:0] {
    SOM_IDLE = 2'h0,
    SOM_WAIT = 2'h1,
    SOM_BURST = 2'h3
  } som_state_t;
endpackage
